// ### src/interval_tick.sv
/*
 Free-running interval counter giving a one-cycle tick every PERIOD cycles while run is high.
 Assumes a synchronous active-high reset; dropping run restarts the interval.
*/
`timescale 1ns/100ps
module interval_tick #(
   parameter int PERIOD = 25
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // control
   input wire logic run,
   output logic tick
);

   localparam int CW = (PERIOD > 1) ? $clog2(PERIOD) : 1;
   localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

   logic [CW-1:0] count;

   always_ff @(posedge clk_sys) begin
      if (sys_rst || !run) begin
         count <= '0;
         tick <= 1'b0;
      end else if (count == LAST) begin
         count <= '0;
         tick <= 1'b1;
      end else begin
         count <= count + CW'(1);
         tick <= 1'b0;
      end
   end

endmodule

// ### src/processor_thermal_throttle.sv
/*
 Overheat throttle unit, catastrophic trip output and frequency boost stepper.
 Assumes temperature, performance requests and limit flags are synchronous to clk_sys.
*/
`timescale 1ns/100ps
module processor_thermal_throttle #(
   parameter logic METHOD = thermal_pkg::METHOD_PSTATE_DROP,
   parameter int BOOST_STEP_CYC = thermal_pkg::BOOST_STEP_CYC,
   parameter int CORES = 4,
   // boost ceiling ratio per active core count, entry 0 for one core
   parameter logic [8*4-1:0] CAP_TABLE = {8'h1E, 8'h20, 8'h22, 8'h23}
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // thermal sensing
   input wire logic [7:0] temp_c,
   // arming
   input wire logic arm_auto,
   input wire logic arm_on_demand,
   input wire logic on_demand_req,
   // operating system performance control
   input wire logic [3:0] os_pstate_req,
   input wire logic workload_demand,
   // boost limits
   input wire logic [2:0] active_cores,
   input wire logic current_limit,
   input wire logic power_limit,
   input wire logic boost_temp_limit,
   // clock and performance outputs
   output logic core_clk_run,
   output logic [3:0] pstate_out,
   output logic [7:0] freq_ratio,
   output logic throttle_active,
   output logic boost_active,
   // system power control
   output logic catastrophic_trip_out
);

   // ==========================================================
   // thermal compare
   // the threshold lives only here as a constant; there is no path to change or read it
   logic hot;
   logic trip_hot;
   assign hot = (temp_c >= thermal_pkg::TJ_MAX_C);
   assign trip_hot = (temp_c >= thermal_pkg::TRIP_C);

   // ==========================================================
   // arming
   logic engage;
   // automatic needs nothing but the sensor; on-demand is a plain request level
   assign engage = (arm_auto && hot) || (arm_on_demand && on_demand_req);

   // ==========================================================
   // throttle state machine
   thermal_pkg::therm_state_e state;
   thermal_pkg::therm_state_e next_state;

   always_comb begin
      next_state = state;
      case (state)
         thermal_pkg::therm_normal: begin
            if (engage) begin
               if (METHOD == thermal_pkg::METHOD_PSTATE_DROP) begin
                  next_state = thermal_pkg::therm_pstate_drop;
               end else begin
                  next_state = thermal_pkg::therm_clock_mod;
               end
            end
         end
         thermal_pkg::therm_clock_mod,
         thermal_pkg::therm_pstate_drop: begin
            if (!engage) begin
               next_state = thermal_pkg::therm_normal;
            end
         end
         default: begin
            next_state = thermal_pkg::therm_normal;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state <= thermal_pkg::therm_normal;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         throttle_active <= 1'b0;
      end else begin
         throttle_active <= (next_state != thermal_pkg::therm_normal);
      end
   end

   // ==========================================================
   // clock modulation: stop and run halves of MOD_HALF_CYC cycles, the first stop half one cycle longer
   logic mod_tick;

   interval_tick #(
      .PERIOD(thermal_pkg::MOD_HALF_CYC)
   ) u_mod_tick (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .run(state == thermal_pkg::therm_clock_mod),
      .tick(mod_tick)
   );

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         core_clk_run <= 1'b1;
      end else if (next_state != thermal_pkg::therm_clock_mod) begin
         // leaving modulation always hands back a running clock
         core_clk_run <= 1'b1;
      end else if (state != thermal_pkg::therm_clock_mod) begin
         core_clk_run <= 1'b0;
      end else if (mod_tick) begin
         core_clk_run <= !core_clk_run;
      end
   end

   // ==========================================================
   // performance state output
   // the request is held by the OS, so following it again restores the prior state
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pstate_out <= thermal_pkg::PSTATE_HIGHEST;
      end else if (next_state == thermal_pkg::therm_pstate_drop) begin
         pstate_out <= thermal_pkg::PSTATE_LOWEST;
      end else begin
         pstate_out <= os_pstate_req;
      end
   end

   // ==========================================================
   // boost stepper
   logic boost_allowed;
   logic limit_hit;
   logic step_tick;
   logic [7:0] core_cap;
   logic [1:0] cap_idx;

   assign boost_allowed = (os_pstate_req == thermal_pkg::PSTATE_HIGHEST)
      && (next_state == thermal_pkg::therm_normal);
   assign limit_hit = current_limit || power_limit || boost_temp_limit;

   // zero cores reads as one; counts beyond the table use its last entry
   always_comb begin
      cap_idx = 2'h0;
      if (active_cores > 3'h1) begin
         cap_idx = (active_cores >= 3'(CORES)) ? 2'(CORES - 1) : 2'(active_cores - 3'h1);
      end
      core_cap = CAP_TABLE[cap_idx*8 +: 8];
   end

   interval_tick #(
      .PERIOD(BOOST_STEP_CYC)
   ) u_step_tick (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .run(boost_allowed && workload_demand),
      .tick(step_tick)
   );

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         freq_ratio <= thermal_pkg::BASE_RATIO;
      end else if (!boost_allowed) begin
         freq_ratio <= thermal_pkg::BASE_RATIO;
      end else if (freq_ratio > core_cap) begin
         // more cores woke up: fall straight to the new ceiling
         freq_ratio <= core_cap;
      end else if (step_tick && workload_demand && !limit_hit && freq_ratio < core_cap) begin
         freq_ratio <= freq_ratio + 8'h01;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         boost_active <= 1'b0;
      end else begin
         boost_active <= boost_allowed && (freq_ratio > thermal_pkg::BASE_RATIO);
      end
   end

   // ==========================================================
   // catastrophic trip
   // sticky until reset: the power supply is expected to drop, nothing else clears it
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         catastrophic_trip_out <= 1'b0;
      end else if (trip_hot) begin
         catastrophic_trip_out <= 1'b1;
      end
   end

endmodule

// ### src/thermal_pkg.sv
/*
 Constants, state type and timing figures shared by the thermal throttle and boost logic.
 Assumes a single 25 MHz system clock and temperatures in whole degrees Celsius.
*/
// Notes on behaviour
// - throttle engages when silicon temperature reaches the 100 C maximum
// - activation threshold is fixed, never user settable nor software readable
// - clock modulation method stops and runs processor clocks at 50% duty
// - performance-state drop method moves to the lowest performance state when hot
// - performance-state drop is the selected thermal method instead of clock modulation
// - automatic and on-demand arming; automatic needs no outside help
// - catastrophic trip output asserts near 125 C so system power shuts down
// - trip output is independent of processor activity and makes no bus cycles
// - boost only after the highest performance state is requested; then above base
// - under demand and below limits, raise frequency 100 MHz per regular interval
// - boost capped by first limit: cores, current, power or temperature
// - maximum boost frequency depends on the number of active cores
package thermal_pkg;

   // ==========================================================
   // temperatures, degrees C
   localparam logic [7:0] TJ_MAX_C = 8'h64;
   localparam logic [7:0] TRIP_C = 8'h7D;

   // ==========================================================
   // clock and timing
   localparam int CLK_MHZ = 25;
   localparam int MOD_HALF_NS = 1000;
   localparam int MOD_HALF_CYC = (MOD_HALF_NS * CLK_MHZ) / 1000;
   localparam int BOOST_STEP_US = 1000;
   localparam int BOOST_STEP_CYC = BOOST_STEP_US * CLK_MHZ;

   // ==========================================================
   // performance states and frequency ratios (ratio unit = one 100 MHz step)
   localparam int STEP_MHZ = 100;
   localparam logic [3:0] PSTATE_HIGHEST = 4'h0;
   localparam logic [3:0] PSTATE_LOWEST = 4'hF;
   localparam logic [7:0] BASE_RATIO = 8'h19;

   // ==========================================================
   // throttle method selection
   localparam logic METHOD_CLOCK_MOD = 1'b0;
   localparam logic METHOD_PSTATE_DROP = 1'b1;

   typedef enum logic [1:0] {
      therm_normal,
      therm_clock_mod,
      therm_pstate_drop
   } therm_state_e;

endpackage

// ### testbench/os_power_model.sv
/*
 Operating system power policy model: performance-state request and workload demand.
 Assumes the bench sets the policy; requests move only just after a clock edge.
*/
`timescale 1ns/100ps
module os_power_model (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // policy
   input wire logic want_max,
   input wire logic busy,
   // requests to the device
   output logic [3:0] os_pstate_req,
   output logic workload_demand
);
   // idle request is a middle state so a restore is told apart from state 0 and 15
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         os_pstate_req <= 4'h3;
         workload_demand <= 1'b0;
      end else begin
         os_pstate_req <= want_max ? 4'h0 : 4'h3;
         workload_demand <= busy;
      end
   end
endmodule

// ### testbench/tb_top.sv
/*
 Self-checking bench for processor_thermal_throttle with an operating system model.
 Assumes a short boost interval of 4 cycles and the default method and cap table.
*/
`timescale 1ns/100ps
module tb_top;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] temp_c = 8'h28;
   logic arm_auto = 1'b1;
   logic arm_on_demand = 1'b0;
   logic on_demand_req = 1'b0;
   logic [2:0] active_cores = 3'd4;
   logic [2:0] lims = 3'h0;
   logic want_max = 1'b0;
   logic busy = 1'b0;
   logic [3:0] os_pstate_req, pstate_out;
   logic [7:0] freq_ratio;
   logic workload_demand, core_clk_run, throttle_active, boost_active, catastrophic_trip_out;
   int num_errors = 0;
   int check_count = 0;
   int cycles = 0;

   os_power_model os_power_model_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .want_max(want_max), .busy(busy), .os_pstate_req(os_pstate_req),
      .workload_demand(workload_demand));
   processor_thermal_throttle #(.BOOST_STEP_CYC(4)) processor_thermal_throttle_inst (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .temp_c(temp_c), .arm_auto(arm_auto),
      .arm_on_demand(arm_on_demand), .on_demand_req(on_demand_req),
      .os_pstate_req(os_pstate_req), .workload_demand(workload_demand),
      .active_cores(active_cores), .current_limit(lims[0]), .power_limit(lims[1]),
      .boost_temp_limit(lims[2]), .core_clk_run(core_clk_run), .pstate_out(pstate_out),
      .freq_ratio(freq_ratio), .throttle_active(throttle_active),
      .boost_active(boost_active), .catastrophic_trip_out(catastrophic_trip_out));

   always #20 clk_sys = ~clk_sys;

   task final_report;
      if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // ========
   // hang guard, well above the few hundred cycles the run needs
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         num_errors++;
         final_report();
      end
   end

   task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task wt(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   // ========
   // scenarios
   task t_throttle;
      @(posedge clk_sys) temp_c <= 8'h63;
      wt(2);
      check("below", 8'(throttle_active), 8'h00);
      @(posedge clk_sys) temp_c <= 8'h64;
      wt(1);
      check("engage", 8'(throttle_active), 8'h01);
      check("pstate", 8'(pstate_out), 8'h0F);
      check("clk_runs", 8'(core_clk_run), 8'h01);
      @(posedge clk_sys) temp_c <= 8'h63;
      wt(1);
      check("release", 8'(throttle_active), 8'h00);
      check("restore", 8'(pstate_out), 8'h03);
      @(posedge clk_sys) arm_auto <= 1'b0;
      temp_c <= 8'h64;
      wt(2);
      check("disarmed", 8'(throttle_active), 8'h00);
      @(posedge clk_sys) arm_on_demand <= 1'b1;
      on_demand_req <= 1'b1;
      temp_c <= 8'h28;
      wt(1);
      check("on_demand", 8'(throttle_active), 8'h01);
      @(posedge clk_sys) on_demand_req <= 1'b0;
      arm_auto <= 1'b1;
      wt(1);
      check("demand_off", 8'(throttle_active), 8'h00);
   endtask

   task t_boost;
      @(posedge clk_sys) want_max <= 1'b1;
      busy <= 1'b1;
      wt(80);
      check("cap_four", freq_ratio, 8'h1E);
      check("boosting", 8'(boost_active), 8'h01);
      @(posedge clk_sys) active_cores <= 3'h1;
      wt(80);
      check("cap_one", freq_ratio, 8'h23);
      @(posedge clk_sys) active_cores <= 3'h2;
      wt(2);
      check("cap_two", freq_ratio, 8'h22);
      for (int i = 0; i < 3; i++) begin
         @(posedge clk_sys) lims <= 3'(1 << i);
         active_cores <= 3'h1;
         wt(40);
         check("limit", freq_ratio, 8'h22);
      end
      @(posedge clk_sys) lims <= 3'h0;
      wt(40);
      check("unlimited", freq_ratio, 8'h23);
      @(posedge clk_sys) want_max <= 1'b0;
      wt(4);
      check("base", freq_ratio, 8'h19);
      check("no_boost", 8'(boost_active), 8'h00);
   endtask

   task t_trip;
      @(posedge clk_sys) temp_c <= 8'h7C;
      wt(2);
      check("no_trip", 8'(catastrophic_trip_out), 8'h00);
      @(posedge clk_sys) temp_c <= 8'h7D;
      wt(1);
      check("trip", 8'(catastrophic_trip_out), 8'h01);
      @(posedge clk_sys) temp_c <= 8'h28;
      wt(20);
      check("trip_held", 8'(catastrophic_trip_out), 8'h01);
   endtask

   initial begin
      wt(3);
      check("rst_freq", freq_ratio, 8'h19);
      check("rst_trip", 8'(catastrophic_trip_out), 8'h00);
      check("rst_boost", 8'(boost_active), 8'h00);
      check("rst_clk", 8'(core_clk_run), 8'h01);
      @(posedge clk_sys) sys_rst <= 1'b0;
      t_throttle();
      t_boost();
      t_trip();
      final_report();
   end
endmodule

// ### testbench/thermal_monitor.sv
/*
 Checker on the throttle, trip and boost outputs of processor_thermal_throttle.
 Assumes the default performance-state drop method and the default core cap table.
*/
`timescale 1ns/100ps
module thermal_monitor (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // stimulus seen by the block
   input wire logic [7:0] temp_c,
   input wire logic arm_auto,
   input wire logic arm_on_demand,
   input wire logic on_demand_req,
   input wire logic [3:0] os_pstate_req,
   input wire logic [2:0] active_cores,
   input wire logic current_limit,
   // block outputs
   input wire logic [3:0] pstate_out,
   input wire logic [7:0] freq_ratio,
   input wire logic throttle_active,
   input wire logic catastrophic_trip_out
);
   // ========
   // setup
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);
   logic engage;
   assign engage = (arm_auto && temp_c >= 8'h64) || (arm_on_demand && on_demand_req);
   // ========
   // assertions
   a_auto_engage: assert property (arm_auto && temp_c >= 8'h64 |=>
      throttle_active && pstate_out == 4'hF) else $error("throttle missed at limit");
   a_demand_engage: assert property (arm_on_demand && on_demand_req |=> throttle_active)
      else $error("on-demand throttle missed");
   a_release_restore: assert property (!engage |=> !throttle_active &&
      pstate_out == $past(os_pstate_req)) else $error("throttle not released");
   a_trip_set: assert property (temp_c >= 8'h7D |=> catastrophic_trip_out)
      else $error("trip missed");
   a_trip_hold: assert property (catastrophic_trip_out |=> catastrophic_trip_out)
      else $error("trip dropped");
   a_boost_gate: assert property (os_pstate_req != 4'h0 |=> freq_ratio == 8'h19)
      else $error("boost without top request");
   a_boost_step: assert property (freq_ratio > $past(freq_ratio) |->
      freq_ratio == $past(freq_ratio) + 8'h01) else $error("boost step not one");
   a_limit_hold: assert property (current_limit [*2] |-> freq_ratio <= $past(freq_ratio))
      else $error("boost rose at limit");
   a_core_cap: assert property ((active_cores == 3'h4) [*2] |-> freq_ratio <= 8'h1E)
      else $error("boost above core cap");
   c_throttle: cover property ($rose(throttle_active));
   c_trip: cover property ($rose(catastrophic_trip_out));
   c_top_cap: cover property (freq_ratio == 8'h23);
endmodule

bind processor_thermal_throttle thermal_monitor thermal_monitor_inst (.clk_sys(clk_sys),
   .sys_rst(sys_rst), .temp_c(temp_c), .arm_auto(arm_auto), .arm_on_demand(arm_on_demand),
   .on_demand_req(on_demand_req), .os_pstate_req(os_pstate_req),
   .active_cores(active_cores), .current_limit(current_limit), .pstate_out(pstate_out),
   .freq_ratio(freq_ratio), .throttle_active(throttle_active),
   .catastrophic_trip_out(catastrophic_trip_out));
